// File: hw/osd_regs.vh
`ifndef OSD_REGS_VH
`define OSD_REGS_VH

// opcode escape range start
`define OSD_OPC_EXT_MIN 8'hFC
// specifier fields
`define OSD_SPEC_MODE 7:4
`define OSD_SPEC_REG 3:0
// addressing modes
`define OSD_MODE_REG 4'h5
`define OSD_MODE_DEFER 4'h6
`define OSD_MODE_AUTODEC 4'h7
`define OSD_MODE_AUTOINC 4'h8
`define OSD_MODE_AINCDEF 4'h9
// special register numbers
`define OSD_REG_PC 4'hF
`define OSD_REG_SP 4'hE
// access types
`define OSD_ACC_READ 3'h0
`define OSD_ACC_WRITE 3'h1
`define OSD_ACC_MODIFY 3'h2
`define OSD_ACC_ADDR 3'h3
`define OSD_ACC_VFIELD 3'h4
`define OSD_ACC_BRANCH 3'h5
// data type classes
`define OSD_DT_BYTE 3'h0
`define OSD_DT_WORD 3'h1
`define OSD_DT_LONG 3'h2
`define OSD_DT_QUAD 3'h3
`define OSD_DT_OCTA 3'h4
// float types share the integer class codes
`define OSD_DT_FFLOAT `OSD_DT_LONG
`define OSD_DT_DFLOAT `OSD_DT_QUAD
`define OSD_DT_GFLOAT `OSD_DT_QUAD
`define OSD_DT_HFLOAT `OSD_DT_OCTA
// operand sizes in bytes
`define OSD_SZ_BYTE 5'h01
`define OSD_SZ_WORD 5'h02
`define OSD_SZ_LONG 5'h04
`define OSD_SZ_QUAD 5'h08
`define OSD_SZ_OCTA 5'h10
// pointer size for deferred autoincrement
`define OSD_PTR_SIZE 5'h04
`endif

// File: hw/osd_decoder.v
`include "osd_regs.vh"

module osd_decoder (
  input wire core_clk,
  input wire reset_n,
  input wire ibValid,
  input wire [7:0] ibByte,
  output reg ibReady_r,
  input wire specValid,
  input wire [2:0] specAccess,
  input wire [2:0] specType,
  input wire nextInsn,
  output reg specReady_r,
  input wire memRdValid,
  input wire [127:0] memRdData,
  output reg memRdReq_r,
  output reg [31:0] memAddr_r,
  output reg [2:0] memSize_r,
  input wire regWe,
  input wire [3:0] regWIdx,
  input wire [31:0] regWData,
  input wire [3:0] regRIdx,
  output reg [31:0] regRData_r,
  output reg opcValid_r,
  output reg [15:0] opcode_r,
  output reg opcLong_r,
  output reg resValid_r,
  output reg [127:0] resData_r,
  output reg [31:0] resAddr_r,
  output reg resAddrOk_r,
  output reg resInReg_r,
  output reg [3:0] resRegIdx_r,
  output reg resBranch_r,
  output reg fault_r,
  output reg unsup_r
);

  ////////////////////////////////////////////////////////////////////////
  // states, one-hot
  localparam [6:0] S_OPC = 7'h01;
  localparam [6:0] S_OPC2 = 7'h02;
  localparam [6:0] S_CTX = 7'h04;
  localparam [6:0] S_SPEC = 7'h08;
  localparam [6:0] S_EXT = 7'h10;
  localparam [6:0] S_PTR = 7'h20;
  localparam [6:0] S_MEM = 7'h40;

  reg [6:0] state_r; // decoder state
  reg [31:0] regs [0:15]; // general registers, 15 is the counter
  reg [2:0] acc_r; // access type of current specifier
  reg [2:0] dt_r; // data type class of current specifier
  reg [3:0] mode_r; // mode of current specifier
  reg [127:0] extBuf_r; // collected extension bytes, little endian
  reg [4:0] extCnt_r; // extension bytes taken so far
  reg [4:0] extLen_r; // extension bytes expected
  reg [31:0] oa_r; // operand address while reading memory
  integer i;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // operand size per data type class
  function [4:0] sizeOf;
    input [2:0] dt;
    begin
      case (dt)
        `OSD_DT_BYTE: sizeOf = `OSD_SZ_BYTE;
        `OSD_DT_WORD: sizeOf = `OSD_SZ_WORD;
        `OSD_DT_LONG: sizeOf = `OSD_SZ_LONG;
        `OSD_DT_QUAD: sizeOf = `OSD_SZ_QUAD;
        `OSD_DT_OCTA: sizeOf = `OSD_SZ_OCTA;
        default: sizeOf = `OSD_SZ_LONG;
      endcase
    end
  endfunction

  // register n+k, wrapping at 16 like the hardware index does
  function [31:0] rdo;
    input [3:0] n;
    input [3:0] k;
    reg [4:0] t;
    begin
      t = {1'b0, n} + {1'b0, k};
      rdo = regs[t[3:0]];
    end
  endfunction

  wire take = ibValid & ibReady_r; // a stream byte moves this edge
  wire [3:0] specMode = ibByte[`OSD_SPEC_MODE];
  wire [3:0] specReg = ibByte[`OSD_SPEC_REG];
  wire [4:0] szNow = sizeOf(dt_r);
  wire [31:0] rn = regs[specReg]; // register n as addressed
  wire [31:0] rnInc = rn + {27'h0000000, szNow};
  wire [31:0] rnDec = rn - {27'h0000000, szNow};
  wire [31:0] rnPtr = rn + {27'h0000000, `OSD_PTR_SIZE};
  wire [6:0] extBase = {extCnt_r[3:0], 3'b000};
  wire [127:0] extFull = extBuf_r | ({120'h0, ibByte} << extBase);
  wire extLast = (extCnt_r + 5'h01) == extLen_r;

  ////////////////////////////////////////////////////////////////////////
  // state change keeps the registered handshakes in step with it
  task goTo;
    input [6:0] s;
    begin
      state_r <= s;
      ibReady_r <= (s == S_OPC) | (s == S_OPC2) | (s == S_SPEC) | (s == S_EXT);
      specReady_r <= (s == S_CTX);
    end
  endtask

  // hand out an operand address, reading memory where data is needed
  task finishAddr;
    input [31:0] a;
    begin
      if (acc_r == `OSD_ACC_READ || acc_r == `OSD_ACC_MODIFY) begin
        // plain read, no lock held toward the later write-back
        memAddr_r <= a;
        memSize_r <= dt_r;
        memRdReq_r <= 1'b1;
        oa_r <= a;
        goTo(S_MEM);
      end else begin
        // address, bit field base and write deliver the address
        resValid_r <= 1'b1;
        resAddr_r <= a;
        resAddrOk_r <= 1'b1;
        resData_r <= (acc_r == `OSD_ACC_WRITE) ? 128'h0 : {96'h0, a};
        goTo(S_CTX);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequencer and register file
  always @(posedge core_clk) begin
    if (!reset_n) begin
      state_r <= S_OPC;
      ibReady_r <= 1'b1;
      specReady_r <= 1'b0;
      memRdReq_r <= 1'b0;
      memAddr_r <= 32'h00000000;
      memSize_r <= 3'h0;
      regRData_r <= 32'h00000000;
      opcValid_r <= 1'b0;
      opcode_r <= 16'h0000;
      opcLong_r <= 1'b0;
      resValid_r <= 1'b0;
      resData_r <= 128'h0;
      resAddr_r <= 32'h00000000;
      resAddrOk_r <= 1'b0;
      resInReg_r <= 1'b0;
      resRegIdx_r <= 4'h0;
      resBranch_r <= 1'b0;
      fault_r <= 1'b0;
      unsup_r <= 1'b0;
      acc_r <= 3'h0;
      dt_r <= 3'h0;
      mode_r <= 4'h0;
      extBuf_r <= 128'h0;
      extCnt_r <= 5'h00;
      extLen_r <= 5'h00;
      oa_r <= 32'h00000000;
      for (i = 0; i < 16; i = i + 1) begin
        regs[i] <= 32'h00000000;
      end
    end else begin
      // one-cycle pulses drop by default
      opcValid_r <= 1'b0;
      resValid_r <= 1'b0;
      fault_r <= 1'b0;
      unsup_r <= 1'b0;
      regRData_r <= regs[regRIdx];
      // execution unit write first, so decoder updates win on a clash
      if (regWe) begin
        regs[regWIdx] <= regWData;
      end
      // every stream byte advances the counter, except autodecrement on register 15, whose later write wins
      if (take) begin
        regs[`OSD_REG_PC] <= regs[`OSD_REG_PC] + 32'h00000001;
      end
      case (state_r)
        S_OPC: begin
          if (take) begin
            opcode_r <= {8'h00, ibByte};
            if (ibByte >= `OSD_OPC_EXT_MIN) begin
              goTo(S_OPC2);
            end else begin
              opcValid_r <= 1'b1;
              opcLong_r <= 1'b0;
              goTo(S_CTX);
            end
          end
        end
        S_OPC2: begin
          if (take) begin
            opcode_r[15:8] <= ibByte;
            opcValid_r <= 1'b1;
            opcLong_r <= 1'b1;
            goTo(S_CTX);
          end
        end
        S_CTX: begin
          // instruction end wins over a pending specifier
          if (nextInsn) begin
            goTo(S_OPC);
          end else if (specValid) begin
            acc_r <= specAccess;
            dt_r <= specType;
            goTo(S_SPEC);
          end
        end
        S_SPEC: begin
          if (take) begin
            mode_r <= specMode;
            resInReg_r <= 1'b0;
            resBranch_r <= 1'b0;
            resRegIdx_r <= specReg;
            if (acc_r == `OSD_ACC_BRANCH) begin
              // no operand, the bytes are the displacement
              extBuf_r <= {120'h0, ibByte};
              if (dt_r == `OSD_DT_BYTE) begin
                resValid_r <= 1'b1;
                resBranch_r <= 1'b1;
                resAddrOk_r <= 1'b0;
                resData_r <= {120'h0, ibByte};
                goTo(S_CTX);
              end else begin
                extCnt_r <= 5'h01;
                extLen_r <= szNow;
                goTo(S_EXT);
              end
            end else begin
              case (specMode)
                `OSD_MODE_REG: begin
                  if (acc_r == `OSD_ACC_ADDR) begin
                    fault_r <= 1'b1;
                    goTo(S_CTX);
                  end else begin
                    resValid_r <= 1'b1;
                    resInReg_r <= 1'b1;
                    resAddrOk_r <= 1'b0;
                    if (acc_r == `OSD_ACC_VFIELD) begin
                      // field sits in n or in n+1 above n
                      resData_r <= {64'h0, rdo(specReg, 4'h1), rn};
                    end else if (dt_r == `OSD_DT_QUAD) begin
                      resData_r <= {64'h0, rdo(specReg, 4'h1), rn};
                    end else if (dt_r == `OSD_DT_OCTA) begin
                      resData_r <= {rdo(specReg, 4'h3), rdo(specReg, 4'h2), rdo(specReg, 4'h1), rn};
                    end else begin
                      resData_r <= {96'h0, rn};
                    end
                    goTo(S_CTX);
                  end
                end
                `OSD_MODE_DEFER: begin
                  finishAddr(rn);
                end
                `OSD_MODE_AUTOINC: begin
                  if (specReg == `OSD_REG_PC) begin
                    // immediate data follows in the stream
                    extBuf_r <= 128'h0;
                    extCnt_r <= 5'h00;
                    extLen_r <= szNow;
                    goTo(S_EXT);
                  end else begin
                    regs[specReg] <= rnInc;
                    finishAddr(rn);
                  end
                end
                `OSD_MODE_AINCDEF: begin
                  if (specReg == `OSD_REG_PC) begin
                    // absolute address follows in the stream
                    extBuf_r <= 128'h0;
                    extCnt_r <= 5'h00;
                    extLen_r <= `OSD_PTR_SIZE;
                    goTo(S_EXT);
                  end else begin
                    regs[specReg] <= rnPtr;
                    memAddr_r <= rn;
                    memSize_r <= `OSD_DT_LONG;
                    memRdReq_r <= 1'b1;
                    goTo(S_PTR);
                  end
                end
                `OSD_MODE_AUTODEC: begin
                  regs[specReg] <= rnDec;
                  finishAddr(rnDec);
                end
                default: begin
                  // literal, displacement and index are decoded elsewhere
                  unsup_r <= 1'b1;
                  goTo(S_CTX);
                end
              endcase
            end
          end
        end
        S_EXT: begin
          if (take) begin
            extBuf_r <= extFull;
            extCnt_r <= extCnt_r + 5'h01;
            if (extLast) begin
              if (acc_r == `OSD_ACC_BRANCH) begin
                resValid_r <= 1'b1;
                resBranch_r <= 1'b1;
                resAddrOk_r <= 1'b0;
                resData_r <= extFull;
                goTo(S_CTX);
              end else if (mode_r == `OSD_MODE_AUTOINC) begin
                // immediate operand straight from the stream
                resValid_r <= 1'b1;
                resAddrOk_r <= 1'b0;
                resData_r <= extFull;
                goTo(S_CTX);
              end else begin
                finishAddr(extFull[31:0]);
              end
            end
          end
        end
        S_PTR: begin
          // pointer word becomes the operand address
          if (memRdValid) begin
            memRdReq_r <= 1'b0;
            finishAddr(memRdData[31:0]);
          end
        end
        S_MEM: begin
          if (memRdValid) begin
            memRdReq_r <= 1'b0;
            resValid_r <= 1'b1;
            resAddr_r <= oa_r;
            resAddrOk_r <= 1'b1;
            resData_r <= memRdData;
            goTo(S_CTX);
          end
        end
        default: begin
          goTo(S_OPC);
        end
      endcase
    end
  end

endmodule

// File: tb/osd_decoder_properties.sv
module osd_decoder_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic ibReady_r,
  input wire logic specValid,
  input wire logic nextInsn,
  input wire logic specReady_r,
  input wire logic memRdValid,
  input wire logic memRdReq_r,
  input wire logic [31:0] memAddr_r,
  input wire logic opcValid_r,
  input wire logic [15:0] opcode_r,
  input wire logic opcLong_r,
  input wire logic resValid_r,
  input wire logic resAddrOk_r,
  input wire logic resInReg_r,
  input wire logic fault_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  // context accepted; nextInsn would win instead
  sequence s_take_spec;
    specReady_r && specValid && !nextInsn;
  endsequence
  // read outstanding, no data yet
  sequence s_mem_wait;
    memRdReq_r && !memRdValid;
  endsequence
  ////////////////////////////////////////////////////////////
  a_long_opcode: assert property (opcValid_r |-> opcLong_r == (opcode_r[7:0] >= 8'hFC))
    else $error("opcode length flag wrong");
  a_short_upper: assert property (opcValid_r && !opcLong_r |-> opcode_r[15:8] == 8'h00)
    else $error("short opcode upper byte set");
  a_opc_to_ctx: assert property (opcValid_r |-> specReady_r && !ibReady_r)
    else $error("no specifier context after opcode");
  a_spec_byte_next: assert property (s_take_spec |=> ibReady_r && !specReady_r)
    else $error("specifier byte not requested");
  a_mem_held: assert property (s_mem_wait |=> memRdReq_r && $stable(memAddr_r))
    else $error("read request dropped or moved");
  a_res_pulse: assert property (resValid_r |=> !resValid_r)
    else $error("result strobe too long");
  a_reg_no_addr: assert property (resValid_r && resInReg_r |-> !resAddrOk_r)
    else $error("register operand claims an address");
  a_fault_alone: assert property (fault_r |-> !resValid_r ##1 !fault_r)
    else $error("fault with result or too long");
  a_req_quiet: assert property (resValid_r |-> !memRdReq_r)
    else $error("read still pending at result");
endmodule

bind osd_decoder osd_decoder_checker u_chk (.core_clk(core_clk), .reset_n(reset_n), .ibReady_r(ibReady_r),
  .specValid(specValid), .nextInsn(nextInsn), .specReady_r(specReady_r), .memRdValid(memRdValid),
  .memRdReq_r(memRdReq_r), .memAddr_r(memAddr_r), .opcValid_r(opcValid_r), .opcode_r(opcode_r),
  .opcLong_r(opcLong_r), .resValid_r(resValid_r), .resAddrOk_r(resAddrOk_r), .resInReg_r(resInReg_r),
  .fault_r(fault_r));

// File: tb/osd_mem_model.sv
module osd_mem_model (
  input wire logic core_clk,
  input wire logic memRdReq_r,
  input wire logic [31:0] memAddr_r,
  output logic memRdValid,
  output logic [127:0] memRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt; // cycles waited on this read
  logic [1:0] lat = 2'h1; // alternates quick and slow answers
  initial begin
    cnt = 2'h0;
    memRdValid = 1'b0;
    memRdData = 128'h0;
  end
  ////////////////////////////////////////////////////////////
  // data is an address pattern; idle bus flips so stale data never matches
  always @(posedge core_clk) begin
    memRdValid <= 1'b0;
    memRdData <= ~memRdData;
    if (memRdReq_r && !memRdValid) begin
      if (cnt == lat) begin
        memRdValid <= 1'b1;
        memRdData <= {4{memAddr_r ^ 32'h5A5A5A5A}};
        cnt <= 2'h0;
        lat <= lat ^ 2'h2;
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule

// File: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset_n, ibValid, specValid, nextInsn, regWe;
  logic [7:0] ibByte;
  logic [2:0] specAccess, specType;
  logic [3:0] regWIdx, regRIdx;
  logic [31:0] regWData;
  wire memRdValid, ibReady_r, specReady_r, memRdReq_r, opcValid_r, opcLong_r, resValid_r;
  wire resAddrOk_r, resInReg_r, resBranch_r, fault_r, unsup_r;
  wire [127:0] memRdData, resData_r;
  wire [31:0] memAddr_r, regRData_r, resAddr_r;
  wire [2:0] memSize_r;
  wire [15:0] opcode_r;
  wire [3:0] resRegIdx_r;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;

  osd_decoder dut (.core_clk, .reset_n, .ibValid, .ibByte, .ibReady_r, .specValid, .specAccess, .specType,
    .nextInsn, .specReady_r, .memRdValid, .memRdData, .memRdReq_r, .memAddr_r, .memSize_r, .regWe, .regWIdx,
    .regWData, .regRIdx, .regRData_r, .opcValid_r, .opcode_r, .opcLong_r, .resValid_r, .resData_r,
    .resAddr_r, .resAddrOk_r, .resInReg_r, .resRegIdx_r, .resBranch_r, .fault_r, .unsup_r);
  osd_mem_model mem (.core_clk, .memRdReq_r, .memAddr_r, .memRdValid, .memRdData);

  ////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // hang guard, far above the hundred or so cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      print_verdict;
    end
  end
  ////////////////////////////////////////////////////////////
  function logic [31:0] rv(input int i); // preset register contents
    return {i[3:0], 28'h0000100};
  endfunction
  function logic [127:0] mf(input logic [31:0] a); // memory pattern
    return {4{a ^ 32'h5A5A5A5A}};
  endfunction
  task chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bytes little endian; valid held until a ready edge takes each
  task send(input logic [63:0] v, input int n);
    int i, k;
    for (i = 0; i < n; i++) begin
      ibValid = 1'b1;
      ibByte = v[8*i +: 8];
      for (k = 0; k < 50 && ibReady_r !== 1'b1; k++) @(negedge core_clk);
      @(negedge core_clk);
    end
    ibValid = 1'b0;
  endtask
  // opcode strobe or any specifier outcome, bounded
  task wait_ev(input bit opc);
    int k;
    for (k = 0; k < 60; k++) begin
      if (opc ? opcValid_r === 1'b1 : (resValid_r === 1'b1 || fault_r === 1'b1 || unsup_r === 1'b1)) break;
      @(negedge core_clk);
    end
    chk(k < 60, 1'b1);
  endtask
  // context held until the decoder leaves its context state
  task do_spec(input logic [2:0] a, input logic [2:0] t, input logic [63:0] v, input int n);
    int k;
    specValid = 1'b1;
    specAccess = a;
    specType = t;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (specReady_r === 1'b1 && k < 50);
    specValid = 1'b0;
    send(v, n);
    wait_ev(1'b0);
  endtask
  task rd_reg(input logic [3:0] i, input logic [31:0] e);
    regRIdx = i;
    @(negedge core_clk);
    chk(regRData_r, e);
  endtask
  ////////////////////////////////////////////////////////////
  task t_opc;
    logic [7:0] b [4];
    int i;
    b = '{8'hFB, 8'hFC, 8'hFF, 8'h10};
    for (i = 0; i < 4; i++) begin
      if (i > 0) begin
        nextInsn = 1'b1;
        @(negedge core_clk);
        nextInsn = 1'b0;
      end
      send({8'h31, b[i]}, b[i] >= 8'hFC ? 2 : 1);
      wait_ev(1'b1);
      chk(opcode_r, b[i] >= 8'hFC ? {8'h31, b[i]} : {8'h00, b[i]});
      chk(opcLong_r, b[i] >= 8'hFC);
    end
  endtask
  // low registers only, so wide operands never wrap
  task t_reg;
    int i;
    for (i = 0; i < 15; i++) begin
      regWe = 1'b1;
      regWIdx = i[3:0];
      regWData = rv(i);
      @(negedge core_clk);
    end
    regWe = 1'b0;
    do_spec(3'h0, 3'h4, 8'h52, 1);
    chk(resData_r, {rv(5), rv(4), rv(3), rv(2)});
    chk(resInReg_r, 1'b1);
    chk(resRegIdx_r, 4'h2);
    do_spec(3'h4, 3'h3, 8'h56, 1);
    chk(resData_r, {64'h0, rv(7), rv(6)});
    do_spec(3'h3, 3'h2, 8'h59, 1);
    chk(fault_r, 1'b1);
    do_spec(3'h0, 3'h2, 8'h59, 1);
    chk(resData_r, {96'h0, rv(9)});
  endtask
  task t_auto;
    logic [31:0] e, p;
    int t;
    do_spec(3'h0, 3'h2, 8'h83, 1);
    chk(resData_r, mf(rv(3)));
    chk(resAddr_r, rv(3));
    rd_reg(4'h3, rv(3) + 4);
    do_spec(3'h1, 3'h1, 8'h73, 1);
    chk(resAddr_r, rv(3) + 2);
    chk(resData_r, 128'h0);
    do_spec(3'h3, 3'h0, 8'h63, 1);
    chk(resData_r, {96'h0, rv(3) + 32'h2});
    p = (rv(3) + 32'h2) ^ 32'h5A5A5A5A;
    do_spec(3'h0, 3'h0, 8'h93, 1);
    chk(resData_r, mf(p));
    chk(memAddr_r, p);
    chk(memSize_r, 3'h0);
    rd_reg(4'h3, rv(3) + 6);
    // every size step, float classes share these codes
    e = rv(4);
    for (t = 0; t < 5; t++) begin
      do_spec(3'h3, t[2:0], 8'h84, 1);
      chk(resAddr_r, e);
      e = e + (32'h1 << t);
    end
    rd_reg(4'h4, e);
    // modify through register deferred: a plain read, write-back is the executor's
    do_spec(3'h2, 3'h2, 8'h64, 1);
    chk(resData_r, mf(e));
    chk(memSize_r, 3'h2);
  endtask
  // immediate only on read access, counter never decremented
  task t_imm;
    do_spec(3'h0, 3'h1, 64'h12348F, 3);
    chk(resData_r, 128'h1234);
    chk(resAddrOk_r, 1'b0);
    // counter has stepped past all 23 stream bytes taken since reset
    rd_reg(4'hF, 32'h00000017);
    do_spec(3'h0, 3'h2, 64'h112233449F, 5);
    chk(resAddr_r, 32'h11223344);
    chk(resData_r, mf(32'h11223344));
    do_spec(3'h5, 3'h0, 8'h7E, 1);
    chk({resBranch_r, resData_r[7:0]}, 9'h17E);
    do_spec(3'h5, 3'h1, 64'h1280, 2);
    chk(resData_r, 128'h1280);
    chk(resBranch_r, 1'b1);
    do_spec(3'h0, 3'h2, 8'h43, 1);
    chk(unsup_r, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////
  // mid-run reset: back to opcode fetch, register file and counter cleared
  task t_reset;
    reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    chk({ibReady_r, specReady_r, memRdReq_r, opcValid_r, resValid_r}, 5'h10);
    rd_reg(4'h3, 32'h00000000);
    send(64'h31FD, 2);
    wait_ev(1'b1);
    chk(opcode_r, 16'h31FD);
    rd_reg(4'hF, 32'h00000002);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {reset_n, ibValid, specValid, nextInsn, regWe} = 5'h00;
    {ibByte, specAccess, specType, regWIdx, regRIdx, regWData} = 0;
    repeat (20) @(negedge core_clk);
    reset_n = 1'b1;
    chk({ibReady_r, opcValid_r, resValid_r}, 3'h4);
    t_opc;
    t_reg;
    t_auto;
    t_imm;
    t_reset;
    print_verdict;
  end
endmodule
